// ==== verilog/chargen_pkg.sv ====
package chargen_pkg;

  // Display clock
  localparam int CLOCK_NS = 40;

  // Analog settle times in ns; defaults only, software tunes them
  localparam int PRE1_NS  = 400;
  localparam int PRE2_NS  = 400;
  localparam int DEINT_NS = 320;
  localparam int RING_NS  = 1200;

  // Least times round up to whole cycles
  localparam int PRE1_CYC  = (PRE1_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int PRE2_CYC  = (PRE2_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int DEINT_CYC = (DEINT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int RING_CYC  = (RING_NS + CLOCK_NS - 1) / CLOCK_NS;

  localparam int DLY_W = 16;
  localparam logic [DLY_W-1:0] PRE1_RESET  = DLY_W'(PRE1_CYC);
  localparam logic [DLY_W-1:0] PRE2_RESET  = DLY_W'(PRE2_CYC);
  localparam logic [DLY_W-1:0] DEINT_RESET = DLY_W'(DEINT_CYC);
  localparam logic [DLY_W-1:0] RING_RESET  = DLY_W'(RING_CYC);

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] PRE1_OFS       = 8'h08;
  localparam logic [7:0] PRE2_OFS       = 8'h0c;
  localparam logic [7:0] DEINT_OFS      = 8'h10;
  localparam logic [7:0] RING_OFS       = 8'h14;
  localparam logic [7:0] GLYPH_ADDR_OFS = 8'h18;
  localparam logic [7:0] GLYPH_DATA_OFS = 8'h1c;
  localparam logic [7:0] STROKE_OFS     = 8'h20;

  // Control register
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // Status register bits
  localparam int ST_PERMIT_BIT  = 0;
  localparam int ST_FIRST_BIT   = 1;
  localparam int ST_COUNT_LSB   = 2;
  localparam int ST_UNBLANK_BIT = 5;
  localparam int ST_BUSY_BIT    = 6;
  localparam int ST_NINTH_BIT   = 7;

  // Held character code: bit 0 is the most significant
  localparam int CODE_W        = 8;
  localparam int FIELD_W       = 3;
  localparam int CTRL_CODE_LSB = 3;
  localparam int MOD_CODE_LSB  = 0;

  // Glyph store
  localparam int GLYPH_W  = 2 * FIELD_W;
  localparam int IDX_W    = 4;
  localparam int GADDR_W  = GLYPH_W + IDX_W;
  localparam int COUNT_W  = 3;
  localparam logic [IDX_W-1:0] NINTH_IDX = 4'h8;
  localparam logic [IDX_W-1:0] FIRST_IDX = 4'h0;

  typedef struct packed {
    logic       last;
    logic       blank;
    logic [2:0] y;
    logic [2:0] x;
  } stroke_s;

  typedef enum logic [3:0] {
    ST_IDLE          = 4'b0000,
    ST_SAMPLE        = 4'b0001,
    ST_SET_UNBLANK   = 4'b0010,
    ST_PRE1          = 4'b0011,
    ST_RESET_UNBLANK = 4'b0100,
    ST_PRE2          = 4'b0101,
    ST_DEINT         = 4'b0110,
    ST_LOAD          = 4'b0111,
    ST_RING          = 4'b1000
  } timer_e;

endpackage

// ==== verilog/char_analysis.sv ====
`timescale 1ns/1ps
// Glyph store: one stroke code per glyph and stroke index
module char_analysis (
  // Clock and reset
  input  wire logic                               clock,
  input  wire logic                               rst,
  // Software load port
  input  wire logic                               we,
  input  wire logic [chargen_pkg::GADDR_W-1:0]    waddr,
  input  wire chargen_pkg::stroke_s               wdata,
  // Stroke lookup
  input  wire logic [chargen_pkg::GLYPH_W-1:0]    glyph,
  input  wire logic [chargen_pkg::IDX_W-1:0]      stroke_idx,
  output chargen_pkg::stroke_s                    code
);

  localparam int DEPTH = 1 << chargen_pkg::GADDR_W;

  chargen_pkg::stroke_s mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // One cycle of lookup latency; timer waits for it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code <= '0;
    end else begin
      code <= mem[{glyph, stroke_idx}];
    end
  end

endmodule

// ==== verilog/char_stroke_timer.sv ====
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Control code bits 2-4, modifier bits 5-7
// - Decode only while decode pulse set
// - Analysis gives stroke count and X-Y points
// - Blank flag dark strokes, end flag last
// - Load strokes in ascending order, on time
// - Latches govern stroke 1; counter the rest
// - Start signal during decode pulse begins character
// - Start with permit sets first-stroke latch
// - One-shot makes stroke 1 samples
// - Stroke drawn unless blank flag present
// - Drawn: unblank latch, then first preintensify
// - Drawn: reset sample idle, second preintensify
// - Dark: blank latch, deintensify before strobe
// - Deintensify shorter than total preintensify
// - Load sample tests end, loads register
// - Sample end clears latch, steps counter
// - Ring delay regenerates samples each stroke
// - Counter 0 to 7, nine strokes maximum
// - Stroke register: X, Y, blank, end
// - End flag starts ending, counter to zero
module char_stroke_timer (
  // Clock and reset
  input  wire logic                             CLOCK,
  input  wire logic                             RST,
  // APB slave
  input  wire logic                             PSEL,
  input  wire logic                             PENABLE,
  input  wire logic                             PWRITE,
  input  wire logic [7:0]                       PADDR,
  input  wire logic [31:0]                      PWDATA,
  output logic [31:0]                           PRDATA,
  output logic                                  PREADY,
  output logic                                  PSLVERR,
  // Character sequencer
  input  wire logic [chargen_pkg::CODE_W-1:0]   CHAR_CODE,
  input  wire logic                             DECODE_TIME_PULSE,
  input  wire logic                             START_CHAR_DISPLAY,
  output logic                                  PERMIT_NEW_DISPLAY,
  output logic                                  CHAR_END,
  output logic                                  BUSY,
  // Character yoke deflection converters
  output chargen_pkg::stroke_s                  STROKE,
  output logic                                  STROKE_STROBE,
  output logic                                  UNBLANK
);

  localparam int DW = chargen_pkg::DLY_W;

  chargen_pkg::timer_e                  state;
  chargen_pkg::stroke_s                 code;
  logic                                 enable;
  logic [DW-1:0]                        pre1_dly;
  logic [DW-1:0]                        pre2_dly;
  logic [DW-1:0]                        deint_dly;
  logic [DW-1:0]                        ring_dly;
  logic [DW-1:0]                        timer;
  logic [chargen_pkg::GADDR_W-1:0]      glyph_addr;
  logic [chargen_pkg::GLYPH_W-1:0]      glyph;
  logic [chargen_pkg::COUNT_W-1:0]      stroke_count;
  logic                                 first_stroke;
  logic                                 ninth;
  logic                                 first_stroke_one_shot;
  logic                                 ring_regen_one_shot;
  logic [chargen_pkg::IDX_W-1:0]        stroke_idx;
  logic                                 wr_access;
  logic                                 rd_setup;
  logic                                 glyph_we;
  logic                                 start;

  // Zero would stall the timer, so a count never goes below one cycle
  function automatic logic [DW-1:0] cycles(input logic [DW-1:0] v);
    cycles = (v == '0) ? DW'(1) : v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      chargen_pkg::CTRL_OFS,
      chargen_pkg::STATUS_OFS,
      chargen_pkg::PRE1_OFS,
      chargen_pkg::PRE2_OFS,
      chargen_pkg::DEINT_OFS,
      chargen_pkg::RING_OFS,
      chargen_pkg::GLYPH_ADDR_OFS,
      chargen_pkg::GLYPH_DATA_OFS,
      chargen_pkg::STROKE_OFS: mapped = 1'b1;
      default:                 mapped = 1'b0;
    endcase
  endfunction

  // Cutoff must beat the total build-up; a setting as long or longer is clipped
  function automatic logic [DW-1:0] deint_cycles();
    logic [DW:0] total;
    logic [DW:0] d;
    total = {1'b0, cycles(pre1_dly)} + {1'b0, cycles(pre2_dly)};
    d     = {1'b0, cycles(deint_dly)};
    if (d >= total) begin
      deint_cycles = DW'(total - (DW+1)'(1));
    end else begin
      deint_cycles = d[DW-1:0];
    end
  endfunction

  // APB decode
  assign PREADY    = 1'b1;
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_setup  = PSEL && !PENABLE && !PWRITE;
  assign PSLVERR   = PSEL && PENABLE && !mapped(PADDR);
  assign glyph_we  = wr_access && (PADDR == chargen_pkg::GLYPH_DATA_OFS);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      enable    <= chargen_pkg::CTRL_ENABLE_RESET;
      pre1_dly  <= chargen_pkg::PRE1_RESET;
      pre2_dly  <= chargen_pkg::PRE2_RESET;
      deint_dly <= chargen_pkg::DEINT_RESET;
      ring_dly  <= chargen_pkg::RING_RESET;
    end else if (wr_access) begin
      case (PADDR)
        chargen_pkg::CTRL_OFS:
          enable <= PWDATA[chargen_pkg::CTRL_ENABLE_BIT];
        chargen_pkg::PRE1_OFS:  pre1_dly  <= PWDATA[DW-1:0];
        chargen_pkg::PRE2_OFS:  pre2_dly  <= PWDATA[DW-1:0];
        chargen_pkg::DEINT_OFS: deint_dly <= PWDATA[DW-1:0];
        chargen_pkg::RING_OFS:  ring_dly  <= PWDATA[DW-1:0];
        default: ;
      endcase
    end
  end

  // Glyph pointer steps after each data write for burst loading
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      glyph_addr <= '0;
    end else if (wr_access && PADDR == chargen_pkg::GLYPH_ADDR_OFS) begin
      glyph_addr <= PWDATA[chargen_pkg::GADDR_W-1:0];
    end else if (glyph_we) begin
      glyph_addr <= glyph_addr + chargen_pkg::GADDR_W'(1);
    end
  end

  // Read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (rd_setup) begin
      PRDATA <= '0;
      case (PADDR)
        chargen_pkg::CTRL_OFS:
          PRDATA[chargen_pkg::CTRL_ENABLE_BIT] <= enable;
        chargen_pkg::STATUS_OFS: begin
          PRDATA[chargen_pkg::ST_PERMIT_BIT]  <= PERMIT_NEW_DISPLAY;
          PRDATA[chargen_pkg::ST_FIRST_BIT]   <= first_stroke;
          PRDATA[chargen_pkg::ST_COUNT_LSB +: chargen_pkg::COUNT_W]
            <= stroke_count;
          PRDATA[chargen_pkg::ST_UNBLANK_BIT] <= UNBLANK;
          PRDATA[chargen_pkg::ST_BUSY_BIT]    <= BUSY;
          PRDATA[chargen_pkg::ST_NINTH_BIT]   <= ninth;
        end
        chargen_pkg::PRE1_OFS:  PRDATA[DW-1:0] <= pre1_dly;
        chargen_pkg::PRE2_OFS:  PRDATA[DW-1:0] <= pre2_dly;
        chargen_pkg::DEINT_OFS: PRDATA[DW-1:0] <= deint_dly;
        chargen_pkg::RING_OFS:  PRDATA[DW-1:0] <= ring_dly;
        chargen_pkg::GLYPH_ADDR_OFS:
          PRDATA[chargen_pkg::GADDR_W-1:0] <= glyph_addr;
        chargen_pkg::STROKE_OFS:
          PRDATA[$bits(chargen_pkg::stroke_s)-1:0] <= STROKE;
        default: ;
      endcase
    end
  end

  // Code taken only with an accepted start; look-ahead pulses while
  // drawing belong to the next character and must not disturb this one
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      glyph <= '0;
    end else if (start) begin
      glyph <= {CHAR_CODE[chargen_pkg::CTRL_CODE_LSB +: chargen_pkg::FIELD_W],
                CHAR_CODE[chargen_pkg::MOD_CODE_LSB +: chargen_pkg::FIELD_W]};
    end
  end

  // Stroke 1 from the latch, 2..8 from the count, 9 after the wrap
  always_comb begin
    if (first_stroke) begin
      stroke_idx = chargen_pkg::FIRST_IDX;
    end else if (ninth) begin
      stroke_idx = chargen_pkg::NINTH_IDX;
    end else begin
      stroke_idx = chargen_pkg::IDX_W'(stroke_count);
    end
  end

  char_analysis i_char_analysis (
    .clock      (CLOCK),
    .rst        (RST),
    .we         (glyph_we),
    .waddr      (glyph_addr),
    .wdata      (chargen_pkg::stroke_s'(PWDATA[7:0])),
    .glyph      (glyph),
    .stroke_idx (stroke_idx),
    .code       (code)
  );

  assign start = START_CHAR_DISPLAY && DECODE_TIME_PULSE && enable
                 && PERMIT_NEW_DISPLAY && (state == chargen_pkg::ST_IDLE);

  // First-stroke latch and permit latch
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      first_stroke       <= 1'b0;
      PERMIT_NEW_DISPLAY <= 1'b1;
    end else if (start) begin
      first_stroke       <= 1'b1;
      PERMIT_NEW_DISPLAY <= 1'b0;
    end else if (state == chargen_pkg::ST_LOAD) begin
      first_stroke <= 1'b0;
      if (code.last) begin
        PERMIT_NEW_DISPLAY <= 1'b1;
      end
    end
  end

  // Stroke counter; the wrap from 7 releases stroke 9
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      stroke_count <= '0;
      ninth        <= 1'b0;
    end else if (state == chargen_pkg::ST_LOAD) begin
      if (code.last) begin
        stroke_count <= '0;
        ninth        <= 1'b0;
      end else begin
        stroke_count <= stroke_count + chargen_pkg::COUNT_W'(1);
        if (stroke_count == '1) begin
          ninth <= 1'b1;
        end
      end
    end
  end

  // Sample pulse sources for stroke 1 and for the ring
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      first_stroke_one_shot <= 1'b0;
      ring_regen_one_shot   <= 1'b0;
    end else begin
      first_stroke_one_shot <= start;
      ring_regen_one_shot   <= (state == chargen_pkg::ST_RING)
                               && (timer == DW'(1));
    end
  end

  // Stroke timer sequence
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= chargen_pkg::ST_IDLE;
      timer <= '0;
    end else begin
      case (state)
        chargen_pkg::ST_IDLE: begin
          if (first_stroke_one_shot) begin
            state <= chargen_pkg::ST_SAMPLE;
          end
        end
        chargen_pkg::ST_SAMPLE: begin
          // Lookup of the newly selected stroke settles here
          state <= chargen_pkg::ST_SET_UNBLANK;
        end
        chargen_pkg::ST_SET_UNBLANK: begin
          if (!code.blank) begin
            timer <= cycles(pre1_dly);
            state <= chargen_pkg::ST_PRE1;
          end else begin
            state <= chargen_pkg::ST_RESET_UNBLANK;
          end
        end
        chargen_pkg::ST_PRE1: begin
          if (timer == DW'(1)) begin
            state <= chargen_pkg::ST_RESET_UNBLANK;
          end else begin
            timer <= timer - DW'(1);
          end
        end
        chargen_pkg::ST_RESET_UNBLANK: begin
          if (code.blank) begin
            timer <= deint_cycles();
            state <= chargen_pkg::ST_DEINT;
          end else begin
            timer <= cycles(pre2_dly);
            state <= chargen_pkg::ST_PRE2;
          end
        end
        chargen_pkg::ST_PRE2,
        chargen_pkg::ST_DEINT: begin
          if (timer == DW'(1)) begin
            state <= chargen_pkg::ST_LOAD;
          end else begin
            timer <= timer - DW'(1);
          end
        end
        chargen_pkg::ST_LOAD: begin
          if (code.last) begin
            state <= chargen_pkg::ST_IDLE;
          end else begin
            timer <= cycles(ring_dly);
            state <= chargen_pkg::ST_RING;
          end
        end
        chargen_pkg::ST_RING: begin
          if (timer == DW'(1)) begin
            state <= chargen_pkg::ST_IDLE;
          end else begin
            timer <= timer - DW'(1);
          end
        end
        default: state <= chargen_pkg::ST_IDLE;
      endcase
      // Ring expiry re-enters sampling for the next stroke
      if (ring_regen_one_shot) begin
        state <= chargen_pkg::ST_SAMPLE;
      end
    end
  end

  // Blank/unblank latch
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      UNBLANK <= 1'b0;
    end else if (state == chargen_pkg::ST_SET_UNBLANK && !code.blank) begin
      UNBLANK <= 1'b1;
    end else if (state == chargen_pkg::ST_RESET_UNBLANK && code.blank) begin
      UNBLANK <= 1'b0;
    end
  end

  // Stroke register and its strobe
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      STROKE        <= '0;
      STROKE_STROBE <= 1'b0;
      CHAR_END      <= 1'b0;
    end else begin
      STROKE_STROBE <= (state == chargen_pkg::ST_LOAD);
      CHAR_END      <= (state == chargen_pkg::ST_LOAD) && code.last;
      if (state == chargen_pkg::ST_LOAD) begin
        STROKE <= code;
      end
    end
  end

  assign BUSY = (state != chargen_pkg::ST_IDLE) || first_stroke_one_shot
                || ring_regen_one_shot;

endmodule

// ==== tb/char_stroke_timer_properties.sv ====
`timescale 1ns/1ps
module char_stroke_timer_checker (
  // Clock and reset
  input wire logic                 CLOCK,
  input wire logic                 RST,
  // APB
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [7:0]           PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic                 PREADY,
  input wire logic                 PSLVERR,
  // Sequencer side
  input wire logic                 DECODE_TIME_PULSE,
  input wire logic                 START_CHAR_DISPLAY,
  input wire logic                 PERMIT_NEW_DISPLAY,
  input wire logic                 CHAR_END,
  input wire logic                 BUSY,
  // Yoke side
  input wire chargen_pkg::stroke_s STROKE,
  input wire logic                 STROKE_STROBE,
  input wire logic                 UNBLANK
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  logic enabled;

  // Mirror of the enable bit; starts are refused while it is low
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      enabled <= chargen_pkg::CTRL_ENABLE_RESET;
    end else if (PSEL && PENABLE && PWRITE
                 && PADDR == chargen_pkg::CTRL_OFS) begin
      enabled <= PWDATA[chargen_pkg::CTRL_ENABLE_BIT];
    end
  end

  sequence took_s;
    START_CHAR_DISPLAY && DECODE_TIME_PULSE && PERMIT_NEW_DISPLAY && !BUSY
      && enabled;
  endsequence
  // Latch, one-shot and samples leave no room for a strobe
  sequence settle_s;
    !STROKE_STROBE [*4];
  endsequence

  reset_state_a: assert property (
    $fell(RST) |-> PERMIT_NEW_DISPLAY && !UNBLANK && !BUSY && STROKE == '0)
    else $error("state after reset wrong");
  start_taken_a: assert property (
    took_s |=> !PERMIT_NEW_DISPLAY && BUSY ##0 settle_s)
    else $error("start not taken");
  first_strobe_a: assert property (
    took_s |-> ##[5:300] STROKE_STROBE)
    else $error("no stroke after start");
  refused_start_a: assert property (
    START_CHAR_DISPLAY && DECODE_TIME_PULSE && !enabled && !BUSY
      |=> !BUSY && $stable(PERMIT_NEW_DISPLAY))
    else $error("start taken while disabled");
  strobe_pulse_a: assert property (
    STROKE_STROBE |=> !STROKE_STROBE)
    else $error("strobe longer than one cycle");
  stroke_hold_a: assert property (
    !STROKE_STROBE |-> $stable(STROKE))
    else $error("stroke register moved without strobe");
  end_last_a: assert property (
    STROKE_STROBE |-> CHAR_END == STROKE.last)
    else $error("end pulse not with last stroke");
  end_permit_a: assert property (
    CHAR_END |-> ##[0:1] PERMIT_NEW_DISPLAY)
    else $error("permit not back after end");
  drawn_lit_a: assert property (
    STROKE_STROBE && !STROKE.blank |-> UNBLANK)
    else $error("drawn stroke blanked");
  dark_off_a: assert property (
    STROKE_STROBE && STROKE.blank |-> !UNBLANK)
    else $error("dark stroke unblanked");
  apb_ready_a: assert property (
    PSEL |-> PREADY)
    else $error("apb wait state");
  apb_error_a: assert property (
    PSEL && PENABLE && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > 8'h20))
    else $error("apb error flag wrong");
endmodule

bind char_stroke_timer char_stroke_timer_checker i_chk (
  .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .DECODE_TIME_PULSE(DECODE_TIME_PULSE),
  .START_CHAR_DISPLAY(START_CHAR_DISPLAY), .CHAR_END(CHAR_END),
  .PERMIT_NEW_DISPLAY(PERMIT_NEW_DISPLAY), .BUSY(BUSY), .STROKE(STROKE),
  .STROKE_STROBE(STROKE_STROBE), .UNBLANK(UNBLANK)
);

// ==== tb/char_sequencer_model.sv ====
`timescale 1ns/1ps
module char_sequencer_model (
  // Clock
  input  wire logic  clock,
  // Stroke timer handshake
  input  wire logic  permit,
  output logic [7:0] char_code,
  output logic       decode_pulse,
  output logic       start
);
  // Cell steps are arbitrary model choices; no deflection is modelled
  localparam int CELL_STEP  = 8;
  localparam int LARGE_STEP = 12;

  logic large_size_latch;
  int   cell_x;

  initial begin
    large_size_latch = 1'b0;
    cell_x = 0;
    char_code = 8'h00;
    decode_pulse = 1'b0;
    start = 1'b0;
  end

  // Size choice holds for all following characters
  task automatic set_mode(input logic [7:0] mode_control_byte);
    large_size_latch = mode_control_byte[0];
  endtask

  // Start rides on the decode pulse for exactly one edge
  task automatic send(input logic [7:0] code, input bit wait_permit);
    while (wait_permit && permit !== 1'b1) @(posedge clock);
    char_code <= code;
    decode_pulse <= 1'b1;
    start <= 1'b1;
    @(posedge clock);
    decode_pulse <= 1'b0;
    start <= 1'b0;
    // Next cell origin worked out while the strokes are drawn
    cell_x <= cell_x + (large_size_latch ? LARGE_STEP : CELL_STEP);
    // Code is not held outside the pulse
    char_code <= ~code;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic                  CLOCK, RST, PSEL, PENABLE, PWRITE;
  logic [7:0]            PADDR;
  logic [31:0]           PWDATA, PRDATA, rd;
  logic                  PREADY, PSLVERR, err, PERMIT_NEW_DISPLAY;
  logic                  CHAR_END, BUSY, STROKE_STROBE, UNBLANK;
  logic                  DECODE_TIME_PULSE, START_CHAR_DISPLAY;
  logic [7:0]            CHAR_CODE;
  chargen_pkg::stroke_s  STROKE, s;
  chargen_pkg::stroke_s  exp_q[$];
  chargen_pkg::stroke_s  glyph_tab[3][9];
  logic [5:0]            gl[3];
  int                    nstk[3] = '{9, 1, 3};
  int                    lat[3];
  int                    bad_count, checks_done;

  char_stroke_timer i_char_stroke_timer (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CHAR_CODE(CHAR_CODE),
    .DECODE_TIME_PULSE(DECODE_TIME_PULSE), .BUSY(BUSY),
    .START_CHAR_DISPLAY(START_CHAR_DISPLAY), .CHAR_END(CHAR_END),
    .PERMIT_NEW_DISPLAY(PERMIT_NEW_DISPLAY), .STROKE(STROKE),
    .STROKE_STROBE(STROKE_STROBE), .UNBLANK(UNBLANK)
  );
  char_sequencer_model seq (
    .clock(CLOCK), .permit(PERMIT_NEW_DISPLAY), .char_code(CHAR_CODE),
    .decode_pulse(DECODE_TIME_PULSE), .start(START_CHAR_DISPLAY)
  );

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // Latency counts edges from the taken start to the first strobe
  task automatic run_char(input int g, output int n);
    int k;
    for (int i = 0; i < nstk[g]; i++) exp_q.push_back(glyph_tab[g][i]);
    seq.send({2'($urandom), gl[g]}, 1'b1);
    n = 0;
    do begin @(posedge CLOCK); n++; end while (STROKE_STROBE !== 1'b1 && n < 500);
    // Start while busy must be dropped
    if (g == 0) seq.send({2'($urandom), gl[1]}, 1'b0);
    k = 0;
    while (PERMIT_NEW_DISPLAY !== 1'b1 && k < 5000) begin
      @(posedge CLOCK);
      k++;
    end
    s = glyph_tab[g][nstk[g]-1];
    rd_chk(chargen_pkg::STATUS_OFS, {26'h0, ~s.blank, 5'h01});
    rd_chk(chargen_pkg::STROKE_OFS, {24'h0, s});
    check(32'(exp_q.size()), 32'h0);
  endtask

  always @(posedge CLOCK) begin
    if (STROKE_STROBE === 1'b1) begin
      check({24'h0, STROKE}, exp_q.size() ? {24'h0, exp_q.pop_front()} : '1);
      check({31'h0, CHAR_END}, {31'h0, STROKE.last});
    end
  end

  initial begin
    repeat (30000) @(posedge CLOCK);
    bad_count++;
    stop_test();
  end

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    bad_count = 0;
    checks_done = 0;
    RST = 1'b1;
    void'($urandom(32'hcaee6287));
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    rd_chk(chargen_pkg::CTRL_OFS, 32'h1);
    rd_chk(chargen_pkg::STATUS_OFS, 32'h1);
    rd_chk(chargen_pkg::PRE1_OFS, 32'(chargen_pkg::PRE1_RESET));
    rd_chk(chargen_pkg::PRE2_OFS, 32'(chargen_pkg::PRE2_RESET));
    rd_chk(chargen_pkg::DEINT_OFS, 32'(chargen_pkg::DEINT_RESET));
    rd_chk(chargen_pkg::RING_OFS, 32'(chargen_pkg::RING_RESET));
    rd_chk(chargen_pkg::GLYPH_DATA_OFS, 32'h0);
    apb(1'b1, 8'h24, 32'hffff_ffff);
    rd_chk(8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
    // Disabled timer must ignore a start
    apb(1'b1, chargen_pkg::CTRL_OFS, 32'h0);
    seq.send(8'($urandom), 1'b1);
    rd_chk(chargen_pkg::STATUS_OFS, 32'h1);
    apb(1'b1, chargen_pkg::CTRL_OFS, 32'h1);
    seq.set_mode(8'($urandom));
    for (int g = 0; g < 3; g++) begin
      gl[g] = {3'($urandom), 3'(g)};
      apb(1'b1, chargen_pkg::GLYPH_ADDR_OFS, {22'h0, gl[g], 4'h0});
      for (int i = 0; i < nstk[g]; i++) begin
        s = 8'($urandom);
        // First stroke dark only for the third glyph
        if (i == 0) s.blank = (g == 2);
        s.last = (i == nstk[g] - 1);
        glyph_tab[g][i] = s;
        apb(1'b1, chargen_pkg::GLYPH_DATA_OFS, {24'h0, s});
      end
    end
    for (int ph = 0; ph < 2; ph++) begin
      apb(1'b1, chargen_pkg::PRE1_OFS, 32'd2);
      apb(1'b1, chargen_pkg::PRE2_OFS, 32'd3);
      apb(1'b1, chargen_pkg::DEINT_OFS, ph ? 32'd20 : 32'd1);
      apb(1'b1, chargen_pkg::RING_OFS, 32'(1 + 2 * ph));
      rd_chk(chargen_pkg::DEINT_OFS, ph ? 32'd20 : 32'd1);
      for (int g = 0; g < 3; g++) run_char(g, lat[g]);
      // Oversized deintensify is clipped below the preintensify sum
      check(32'(lat[0] - lat[2]), ph ? 32'd1 : 32'd4);
      check(32'(lat[0] - lat[1]), 32'h0);
    end
    stop_test();
  end
endmodule
